//--- src/tgw_pkg.sv
// Constants and types shared by the tape gap watch and write sequencer
package tgw_pkg;

	// ----------------------------------------------------------------
	// Timing
	// ----------------------------------------------------------------
	localparam int unsigned CLK_PERIOD_NS   = 40;
	localparam int unsigned GAP_PASS_NS     = 200;
	localparam int unsigned GAP_PASS_CYC    = (GAP_PASS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int unsigned BIT_TIMER_NS    = 20000;
	localparam int unsigned BIT_TIMER_CYC   = BIT_TIMER_NS / CLK_PERIOD_NS;

	// ----------------------------------------------------------------
	// Register byte addresses
	// ----------------------------------------------------------------
	localparam logic [7:0] ADR_CTRL      = 8'h00;
	localparam logic [7:0] ADR_CMD_STAT  = 8'h04;
	localparam logic [7:0] ADR_GAP_LIMIT = 8'h08;
	localparam logic [7:0] ADR_TIMER_PER = 8'h0C;
	localparam logic [7:0] ADR_SEQ_CMD   = 8'h10;
	localparam logic [7:0] ADR_WR_STORE  = 8'h14;
	localparam logic [7:0] ADR_STATUS    = 8'h18;
	localparam logic [7:0] ADR_GAP_COUNT = 8'h1C;
	localparam logic [7:0] ADR_STAT_CLR  = 8'h20;

	// ----------------------------------------------------------------
	// Field positions
	// ----------------------------------------------------------------
	localparam int unsigned CTRL_WR_ACT  = 0;
	localparam int unsigned CTRL_GAP_GO  = 1;
	localparam int unsigned CTRL_ERR_EN  = 2;
	localparam int unsigned CLR_STOPPED  = 0;
	localparam int unsigned CLR_ABORTED  = 1;
	localparam int unsigned CLR_SIND     = 2;

	// ----------------------------------------------------------------
	// Values
	// ----------------------------------------------------------------
	localparam logic [7:0]  GAP_LIMIT_RST = 8'h09;
	localparam logic [7:0]  SEARCH_EOT    = 8'hAA;
	localparam logic [7:0]  FMS_MASK      = 8'h0B;
	localparam logic [7:0]  FMS_MATCH     = 8'h05;
	localparam logic [7:0]  ZPH_DATA      = 8'h00;
	localparam logic [7:0]  ZPH_PARITY    = 8'h00;
	localparam logic [7:0]  ZDT_DATA      = 8'hFF;
	localparam logic [7:0]  ZDT_PARITY    = 8'h02;
	localparam logic [7:0]  ONES_BYTE     = 8'h00;
	localparam logic [15:0] TIMER_PER_RST = 16'(BIT_TIMER_CYC);

	// Sequence opcodes in SEQ_CMD[2:0]
	localparam logic [2:0] OP_ONES      = 3'h1;
	localparam logic [2:0] OP_ONES_SKIP = 3'h2;
	localparam logic [2:0] OP_ZEROS     = 3'h3;
	localparam logic [2:0] OP_DATA      = 3'h4;

	typedef enum logic [3:0] {
		ST_IDLE,
		ST_ODLY1,
		ST_OLOAD,
		ST_ODLY2,
		ST_ZPH,
		ST_ZW1,
		ST_ZDAT,
		ST_ZW2,
		ST_DWAIT,
		ST_DLD
	} tgw_seq_e;

endpackage

//--- src/tgw_top.sv
// Gap-length watchdog, search indicator and write sequences of a tape formatter
//
// Added by the designer: the placing of the registers and the Wishbone interface to the registers.
`timescale 1ns/1ns
module tgw_top
	import tgw_pkg::*;
#(
	parameter int unsigned PASS_CYC = GAP_PASS_CYC
) (
	input  wire logic        CORE_CLK,
	input  wire logic        RST_N,
	input  wire logic        WB_CYC_I,
	input  wire logic        WB_STB_I,
	input  wire logic        WB_WE_I,
	input  wire logic [7:0]  WB_ADR_I,
	input  wire logic [3:0]  WB_SEL_I,
	input  wire logic [31:0] WB_DAT_I,
	output logic             WB_ACK_O,
	output logic      [31:0] WB_DAT_O,
	input  wire logic        FORMATTER_BUSY,
	input  wire logic        EOT_MARK,
	input  wire logic        DATA_DETECTED,
	input  wire logic        TRANSPORT_WRITE_STROBE,
	output logic      [7:0]  WR_DATA,
	output logic      [7:0]  WR_PARITY,
	output logic             WR_LOAD,
	output logic             TAPE_STOP,
	output logic             ERR_DETECT_EN,
	output logic             SEQ_BUSY,
	output logic             TIMER_LATCH
);

	if (PASS_CYC < 1 || PASS_CYC > 256) begin : g_bad_pass
		$error("PASS_CYC must lie in 1..256");
	end

	// ----------------------------------------------------------------
	// Reset release
	// ----------------------------------------------------------------
	logic rst_meta_r;
	logic rst_n_sync;

	always_ff @(posedge CORE_CLK or negedge RST_N) begin
		if (!RST_N) begin
			rst_meta_r <= 1'b0;
			rst_n_sync <= 1'b0;
		end else begin
			rst_meta_r <= 1'b1;
			rst_n_sync <= rst_meta_r;
		end
	end

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	typedef struct packed {
		logic        ack;
		logic [31:0] rdat;
		logic        wr_act;
		logic        gap_run;
		logic [7:0]  cmd_stat;
		logic [7:0]  gap_lim;
		logic [15:0] tper;
		logic [15:0] tcnt;
		logic        tlatch;
		logic [7:0]  wd;
		logic [7:0]  wp;
		logic [7:0]  sind;
		logic        stopped;
		logic        aborted;
		logic [7:0]  pcnt;
		logic [7:0]  g_lo;
		logic [7:0]  g_mid;
		logic [7:0]  g_hi;
		tgw_seq_e    st;
		logic [7:0]  rpt;
		logic [7:0]  wr_data;
		logic [7:0]  wr_par;
		logic        wr_load;
		logic        pend;
		logic        err_en;
		logic        tape_stop;
	} tgw_state_s;

	tgw_state_s q_r;
	tgw_state_s q_nxt;

	function automatic logic [31:0] lane_merge(input logic [31:0] old_v, input logic [31:0] new_v,
		input logic [3:0] sel);
		logic [31:0] res;
		res = old_v;
		for (int i = 0; i < 4; i++) begin
			if (sel[i]) begin
				res[8*i +: 8] = new_v[8*i +: 8];
			end
		end
		return res;
	endfunction

	// Helper terms; pass_tick, fms_abort and gap_start are also watched by the checks below
	logic pass_tick;
	logic fms_abort;
	logic dly_ok;
	logic wb_wr;
	logic gap_start;

	assign pass_tick = q_r.gap_run && (q_r.pcnt == 8'(PASS_CYC - 1));
	assign fms_abort = (q_r.sind == SEARCH_EOT) && ((q_r.cmd_stat & FMS_MASK) == FMS_MATCH)
		&& !DATA_DETECTED;
	// A delay ends on the latch, but not while a loaded byte still awaits its strobe
	assign dly_ok    = q_r.tlatch && !(q_r.wr_act && q_r.pend);
	assign wb_wr     = WB_CYC_I && WB_STB_I && WB_WE_I && q_r.ack;
	assign gap_start = wb_wr && (WB_ADR_I == ADR_CTRL) && WB_SEL_I[0] && WB_DAT_I[CTRL_GAP_GO]
		&& !FORMATTER_BUSY && !q_r.gap_run;

	always_comb begin
		tgw_state_s n;
		logic [31:0] merged;
		logic        clr_latch;
		logic        do_load;
		logic        stop_now;
		logic        ld_sel;
		logic [7:0]  lo_inc;
		logic [7:0]  mid_inc;
		logic [7:0]  hi_inc;
		n         = q_r;
		merged    = 32'h0000_0000;
		clr_latch = 1'b0;
		do_load   = 1'b0;
		stop_now  = 1'b0;
		ld_sel    = 1'b0;
		lo_inc    = q_r.g_lo + 8'h01;
		mid_inc   = q_r.g_mid + 8'h01;
		hi_inc    = q_r.g_hi + 8'h01;
		n.wr_load   = 1'b0;
		n.tape_stop = 1'b0;

		// ------------------------------------------------------------
		// Wishbone slave: one wait state, ack for one cycle
		// ------------------------------------------------------------
		n.ack = WB_CYC_I && WB_STB_I && !q_r.ack;
		if (WB_CYC_I && WB_STB_I && !q_r.ack) begin
			unique case (WB_ADR_I)
				ADR_CTRL:      n.rdat = {29'h0000_0000, q_r.err_en, q_r.gap_run, q_r.wr_act};
				ADR_CMD_STAT:  n.rdat = {24'h00_0000, q_r.cmd_stat};
				ADR_GAP_LIMIT: n.rdat = {24'h00_0000, q_r.gap_lim};
				ADR_TIMER_PER: n.rdat = {16'h0000, q_r.tper};
				ADR_SEQ_CMD:   n.rdat = {16'h0000, q_r.rpt, 4'h0, q_r.st};
				ADR_WR_STORE:  n.rdat = {16'h0000, q_r.wp, q_r.wd};
				ADR_STATUS:    n.rdat = {16'h0000, q_r.sind, 3'h0, q_r.pend, q_r.tlatch,
					q_r.aborted, q_r.stopped, q_r.st != ST_IDLE};
				ADR_GAP_COUNT: n.rdat = {8'h00, q_r.g_hi, q_r.g_mid, q_r.g_lo};
				default:       n.rdat = 32'h0000_0000;
			endcase
		end
		if (wb_wr) begin
			unique case (WB_ADR_I)
				ADR_CTRL: begin
					if (WB_SEL_I[0]) begin
						n.wr_act = WB_DAT_I[CTRL_WR_ACT];
						n.err_en = WB_DAT_I[CTRL_ERR_EN];
					end
				end
				ADR_CMD_STAT: begin
					merged     = lane_merge({24'h00_0000, q_r.cmd_stat}, WB_DAT_I, WB_SEL_I);
					n.cmd_stat = merged[7:0];
				end
				ADR_GAP_LIMIT: begin
					merged    = lane_merge({24'h00_0000, q_r.gap_lim}, WB_DAT_I, WB_SEL_I);
					n.gap_lim = merged[7:0];
				end
				ADR_TIMER_PER: begin
					merged = lane_merge({16'h0000, q_r.tper}, WB_DAT_I, WB_SEL_I);
					n.tper = merged[15:0];
				end
				ADR_WR_STORE: begin
					merged = lane_merge({16'h0000, q_r.wp, q_r.wd}, WB_DAT_I, WB_SEL_I);
					n.wd   = merged[7:0];
					n.wp   = merged[15:8];
				end
				ADR_SEQ_CMD: begin
					// Ignored while a sequence runs
					if (q_r.st == ST_IDLE && WB_SEL_I[0] && WB_SEL_I[1]) begin
						n.rpt = WB_DAT_I[15:8];
						unique case (WB_DAT_I[2:0])
							OP_ONES:      n.st = ST_ODLY1;
							OP_ONES_SKIP: n.st = ST_OLOAD;
							OP_ZEROS:     n.st = ST_ZPH;
							OP_DATA:      n.st = ST_DWAIT;
							default:      n.st = ST_IDLE;
						endcase
					end
				end
				ADR_STAT_CLR: begin
					if (WB_SEL_I[0]) begin
						if (WB_DAT_I[CLR_STOPPED]) begin
							n.stopped = 1'b0;
						end
						if (WB_DAT_I[CLR_ABORTED]) begin
							n.aborted = 1'b0;
						end
						if (WB_DAT_I[CLR_SIND]) begin
							n.sind = 8'h00;
						end
					end
				end
				default: begin
				end
			endcase
		end

		// ------------------------------------------------------------
		// Search indicator; EOT wins over a software clear
		// ------------------------------------------------------------
		if (EOT_MARK) begin
			n.sind = SEARCH_EOT;
		end

		// ------------------------------------------------------------
		// Gap watchdog: counts fixed-length passes, so a stalled tape
		// still times out
		// ------------------------------------------------------------
		if (gap_start) begin
			n.gap_run = 1'b1;
			n.pcnt    = 8'h00;
			n.g_lo    = 8'h00;
			n.g_mid   = 8'h00;
			n.g_hi    = 8'h00;
		end else if (q_r.gap_run) begin
			n.pcnt = pass_tick ? 8'h00 : q_r.pcnt + 8'h01;
			if (pass_tick) begin
				if (fms_abort) begin
					stop_now  = 1'b1;
					n.aborted = 1'b1;
				end else begin
					n.g_lo = lo_inc;
					if (lo_inc == 8'h00) begin
						n.g_mid = mid_inc;
						if (mid_inc == 8'h00) begin
							n.g_hi = hi_inc;
							if (hi_inc == q_r.gap_lim) begin
								stop_now  = 1'b1;
								n.stopped = 1'b1;
							end
						end
					end
				end
			end
		end
		if (stop_now) begin
			n.tape_stop = 1'b1;
			n.gap_run   = 1'b0;
		end

		// ------------------------------------------------------------
		// Write sequencer
		// ------------------------------------------------------------
		unique case (q_r.st)
			ST_IDLE: begin
			end
			ST_ODLY1: begin
				if (dly_ok) begin
					clr_latch = 1'b1;
					n.st      = ST_OLOAD;
				end
			end
			ST_OLOAD: begin
				// Inverted polarity: a zero byte records ones
				n.wr_data = ONES_BYTE;
				n.wr_par  = ONES_BYTE;
				do_load   = 1'b1;
				n.st      = ST_ODLY2;
			end
			ST_ODLY2: begin
				if (dly_ok) begin
					clr_latch = 1'b1;
					n.rpt     = q_r.rpt - 8'h01;
					n.st      = (q_r.rpt == 8'h01) ? ST_IDLE : ST_OLOAD;
				end
			end
			ST_ZPH: begin
				n.wr_data = ZPH_DATA;
				n.wr_par  = ZPH_PARITY;
				do_load   = 1'b1;
				clr_latch = 1'b1;
				n.st      = ST_ZW1;
			end
			ST_ZW1: begin
				if (dly_ok) begin
					n.st = ST_ZDAT;
				end
			end
			ST_ZDAT: begin
				n.wr_data = ZDT_DATA;
				n.wr_par  = ZDT_PARITY;
				do_load   = 1'b1;
				clr_latch = 1'b1;
				n.st      = ST_ZW2;
			end
			ST_ZW2: begin
				if (dly_ok) begin
					n.rpt = q_r.rpt - 8'h01;
					n.st  = (q_r.rpt == 8'h01) ? ST_IDLE : ST_ZPH;
				end
			end
			ST_DWAIT: begin
				if (dly_ok) begin
					n.st = ST_DLD;
				end
			end
			ST_DLD: begin
				n.wr_data = ~q_r.wd;
				n.wr_par  = ~q_r.wp;
				do_load   = 1'b1;
				clr_latch = 1'b1;
				n.st      = ST_IDLE;
			end
			default: n.st = ST_IDLE;
		endcase

		if ((q_r.st == ST_ZPH || q_r.st == ST_ZW1 || q_r.st == ST_ZDAT || q_r.st == ST_ZW2)
			&& DATA_DETECTED) begin
			n.err_en = 1'b1;
		end

		// With writes off WR_LOAD stays low while WR_DATA and WR_PARITY still change, so the sequence is only a delay
		ld_sel    = do_load && q_r.wr_act;
		n.wr_load = ld_sel;
		if (ld_sel) begin
			n.pend = 1'b1;
		end else if (TRANSPORT_WRITE_STROBE) begin
			n.pend = 1'b0;
		end

		// ------------------------------------------------------------
		// Bit-period timer; a set wins over a clear in the same cycle
		// ------------------------------------------------------------
		if ({1'b0, q_r.tcnt} + 17'h0_0001 >= {1'b0, q_r.tper}) begin
			n.tcnt   = 16'h0000;
			n.tlatch = 1'b1;
		end else begin
			n.tcnt   = q_r.tcnt + 16'h0001;
			n.tlatch = q_r.tlatch && !clr_latch;
		end

		q_nxt = n;
	end

	always_ff @(posedge CORE_CLK or negedge rst_n_sync) begin
		if (!rst_n_sync) begin
			q_r         <= '0;
			q_r.st      <= ST_IDLE;
			q_r.gap_lim <= GAP_LIMIT_RST;
			q_r.tper    <= TIMER_PER_RST;
		end else begin
			q_r <= q_nxt;
		end
	end

	assign WB_ACK_O      = q_r.ack;
	assign WB_DAT_O      = q_r.rdat;
	assign WR_DATA       = q_r.wr_data;
	assign WR_PARITY     = q_r.wr_par;
	assign WR_LOAD       = q_r.wr_load;
	assign TAPE_STOP     = q_r.tape_stop;
	assign ERR_DETECT_EN = q_r.err_en;
	assign SEQ_BUSY      = q_r.st != ST_IDLE;
	assign TIMER_LATCH   = q_r.tlatch;

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge CORE_CLK); endclocking
	default disable iff (!rst_n_sync);

	chk_limit_stops: assert property (pass_tick && !fms_abort && q_r.g_lo == 8'hFF && q_r.g_mid == 8'hFF
		&& q_r.g_hi + 8'h01 == q_r.gap_lim |=> TAPE_STOP && !q_r.gap_run && q_r.stopped)
		else $error("gap limit reached without tape stop");
	chk_abort_search: assert property (pass_tick && fms_abort |=> TAPE_STOP && q_r.aborted)
		else $error("file search at EOT did not abort");
	chk_eot_loads: assert property (EOT_MARK |=> q_r.sind == SEARCH_EOT)
		else $error("EOT did not load search indicator");
	chk_mid_carry: assert property (pass_tick && !fms_abort && q_r.g_lo == 8'hFF
		|=> q_r.g_lo == 8'h00 && q_r.g_mid == $past(q_r.g_mid) + 8'h01)
		else $error("middle gap counter missed carry");
	chk_gap_cleared: assert property (gap_start |=> q_r.gap_run && q_r.g_lo == 8'h00
		&& q_r.g_mid == 8'h00 && q_r.g_hi == 8'h00)
		else $error("gap counters not cleared at start");
	chk_strobe_hold: assert property ((q_r.st == ST_ODLY2 || q_r.st == ST_DWAIT) && q_r.wr_act && q_r.pend
		|=> q_r.st == $past(q_r.st))
		else $error("delay ended before write strobe");
	// The latch may only stand after the phase load if the timer set it in that same cycle
	chk_zero_bytes: assert property (q_r.st == ST_ZPH |=> WR_DATA == ZPH_DATA && WR_PARITY == ZPH_PARITY
		&& q_r.st == ST_ZW1 && (!TIMER_LATCH
		|| ({1'b0, $past(q_r.tcnt)} + 17'h0_0001 >= {1'b0, $past(q_r.tper)})))
		else $error("zeros phase byte wrong");
	chk_zero_data: assert property (q_r.st == ST_ZDAT |=> WR_DATA == ZDT_DATA && WR_PARITY == ZDT_PARITY)
		else $error("zeros data byte wrong");
	chk_load_gated: assert property (WR_LOAD |-> $past(q_r.wr_act))
		else $error("write load issued with writes off");
	chk_data_invert: assert property (q_r.st == ST_DLD |=> WR_DATA == ~$past(q_r.wd)
		&& WR_PARITY == ~$past(q_r.wp) && !SEQ_BUSY)
		else $error("data byte not inverted or writer did not finish");
	chk_err_enable: assert property ((q_r.st == ST_ZW1 || q_r.st == ST_ZW2) && DATA_DETECTED
		|=> ERR_DETECT_EN)
		else $error("error detection not enabled on data");

endmodule

//--- testbench/tgw_tape_model.sv
// Behavioural model of the tape transport write and read channels
`timescale 1ns/1ns
module tgw_tape_model (
	input  wire logic clk,
	input  wire logic wr_load,
	input  wire logic slow,
	input  wire logic ddet_req,
	input  wire logic eot_req,
	output logic      write_strobe,
	output logic      data_detected,
	output logic      eot_mark
);
	int cnt = 0;

	initial begin
		write_strobe = 1'b0;
		data_detected = 1'b0;
		eot_mark = 1'b0;
	end

	// Each loaded byte is strobed later; slow mode outlasts a timer period
	always @(posedge clk) begin
		write_strobe <= 1'b0;
		if (wr_load === 1'b1)
			cnt <= slow ? 60 : 3;
		else if (cnt > 1)
			cnt <= cnt - 1;
		else if (cnt == 1) begin
			cnt <= 0;
			write_strobe <= 1'b1;
		end
	end

	always @(posedge clk) begin
		data_detected <= ddet_req;
		eot_mark <= eot_req;
	end
endmodule

//--- testbench/tb.sv
// Self-checking testbench for the gap watch and write sequencer
`timescale 1ns/1ns
module tb;
	import tgw_pkg::*;
	logic        clk = 1'b0, rst_n = 1'b0, cyc = 1'b0, stb = 1'b0, we = 1'b0;
	logic        busy = 1'b0, slow = 1'b1, ddet = 1'b0, eot = 1'b0;
	logic [3:0]  sel = 4'hF;
	logic [7:0]  adr = 8'h00;
	logic [31:0] dat = 32'h0000_0000;
	logic        ack, strobe, ddet_w, eot_w, wr_load, stop, err_en, seq_busy, tlatch;
	logic [31:0] rdat, rd;
	logic [7:0]  wr_data, wr_par;
	logic [15:0] ld_q[$];
	int          errors = 0, total_checks = 0, cycles = 0, loads = 0, outst = 0, t0;

	tgw_top #(.PASS_CYC(1)) u_dut (
		.CORE_CLK(clk), .RST_N(rst_n), .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we),
		.WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(dat), .WB_ACK_O(ack), .WB_DAT_O(rdat),
		.FORMATTER_BUSY(busy), .EOT_MARK(eot_w), .DATA_DETECTED(ddet_w),
		.TRANSPORT_WRITE_STROBE(strobe), .WR_DATA(wr_data), .WR_PARITY(wr_par), .WR_LOAD(wr_load),
		.TAPE_STOP(stop), .ERR_DETECT_EN(err_en), .SEQ_BUSY(seq_busy), .TIMER_LATCH(tlatch));

	tgw_tape_model u_tape (.clk(clk), .wr_load(wr_load), .slow(slow), .ddet_req(ddet), .eot_req(eot),
		.write_strobe(strobe), .data_detected(ddet_w), .eot_mark(eot_w));

	initial forever #20 clk = ~clk;

	task automatic close_out();
		$display("checks %0d errors %0d", total_checks, errors);
		if (errors == 0 && total_checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
		total_checks++;
		if (got !== exp) begin
			errors++;
			$display("MISMATCH %s expected %h seen %h", name, exp, got);
		end
	endtask

	// Classic single cycle; the master holds everything until ack is sampled
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clk);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		dat <= d;
		do begin
			@(posedge clk);
			n++;
		end while (ack !== 1'b1 && n < 20);
		rd = rdat;
		chk("bus ack", 1, ack);
		cyc <= 1'b0;
		stb <= 1'b0;
		we <= 1'b0;
	endtask

	task automatic rchk(input string name, input logic [7:0] a, input logic [31:0] exp);
		wb(1'b0, a, 32'h0000_0000);
		chk(name, exp, rd);
	endtask

	function automatic logic cond(input int k);
		case (k)
			0: return tlatch;
			1: return stop;
			2: return seq_busy === 1'b0;
			default: return outst == 0;
		endcase
	endfunction

	task automatic wait_for(input int k, input int lim, input string name);
		int n;
		n = 0;
		while (cond(k) !== 1'b1 && n < lim) begin
			@(posedge clk);
			n++;
		end
		chk(name, 1, cond(k));
	endtask

	task automatic run_seq(input logic [2:0] op, input logic [7:0] cnt);
		wb(1'b1, ADR_SEQ_CMD, {16'h0000, cnt, 5'h00, op});
		repeat (2) @(posedge clk);
		wait_for(2, 3000, "sequence done");
	endtask

	// ----------------------------------------------------------------
	// Load monitor and cycle limit
	// ----------------------------------------------------------------
	always @(posedge clk) begin
		cycles++;
		if (cycles > 90000) begin
			errors++;
			close_out();
		end else begin
			if (strobe === 1'b1)
				outst = 0;
			if (wr_load === 1'b1) begin
				chk("load before strobe", 0, outst);
				outst = 1;
				loads++;
				ld_q.push_back({wr_data, wr_par});
			end
		end
	end

	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial begin
		repeat (10) @(posedge clk);
		rst_n <= 1'b1;
		repeat (3) @(posedge clk);
		rchk("gap limit", ADR_GAP_LIMIT, 32'(GAP_LIMIT_RST));
		rchk("timer period", ADR_TIMER_PER, 32'(TIMER_PER_RST));
		rchk("unmapped", 8'h3C, 32'h0000_0000);
		wb(1'b1, ADR_TIMER_PER, 32'h0000_0014);
		wb(1'b1, ADR_CTRL, 32'h0000_0001);
		wait_for(0, 600, "timer latch");
		// Slow strobes make each delay after a load wait for the transport
		run_seq(OP_ONES, 8'h02);
		chk("ones loads", 2, loads);
		chk("ones byte", 8'h00, ld_q[1][15:8]);
		slow <= 1'b0;
		wait_for(3, 200, "strobe idle");
		loads = 0;
		wb(1'b1, ADR_SEQ_CMD, 32'h0000_0102);
		// Load must show in the second cycle after the accepted write, with no delay before it
		repeat (2) @(posedge clk);
		chk("skip entry load", 1, wr_load);
		wait_for(2, 3000, "skip done");
		wb(1'b1, ADR_CTRL, 32'h0000_0000);
		run_seq(OP_ONES, 8'h03);
		chk("writes off loads", 1, loads);
		wb(1'b1, ADR_CTRL, 32'h0000_0001);
		ld_q.delete();
		loads = 0;
		wb(1'b1, ADR_SEQ_CMD, {16'h0000, 8'h02, 5'h00, OP_ZEROS});
		repeat (3) @(posedge clk);
		chk("err detect early", 0, err_en);
		ddet <= 1'b1;
		wait_for(2, 3000, "zeros done");
		chk("err detect on", 1, err_en);
		chk("zeros loads", 4, loads);
		chk("zeros phase", 16'h0000, ld_q[2]);
		chk("zeros data", 16'hFF02, ld_q[3]);
		slow <= 1'b1;
		wait_for(3, 200, "strobe idle");
		wb(1'b1, ADR_WR_STORE, 32'h0000_A53C);
		run_seq(OP_DATA, 8'h01);
		// The load pulse ends with the sequence; let the monitor count it first
		@(posedge clk);
		chk("data loads", 5, loads);
		chk("data byte", 16'hC35A, ld_q[4]);
		chk("no trailing wait", 1, outst);
		busy <= 1'b1;
		ddet <= 1'b0;
		wb(1'b1, ADR_CTRL, 32'h0000_0003);
		rchk("gap refused", ADR_CTRL, 32'h0000_0001);
		busy <= 1'b0;
		eot <= 1'b1;
		repeat (3) @(posedge clk);
		eot <= 1'b0;
		wb(1'b0, ADR_STATUS, 32'h0000_0000);
		chk("search indicator", 8'hAA, rd[15:8]);
		wb(1'b1, ADR_GAP_LIMIT, 32'h0000_0001);
		wb(1'b1, ADR_CMD_STAT, 32'h0000_0005);
		wb(1'b1, ADR_CTRL, 32'h0000_0003);
		t0 = cycles;
		wb(1'b0, ADR_GAP_COUNT, 32'h0000_0000);
		chk("gap high early", 0, rd[23:16]);
		wait_for(1, 70000, "tape stop");
		chk("gap passes", 1, (cycles - t0 >= 65536) && (cycles - t0 <= 65546));
		rchk("gap count end", ADR_GAP_COUNT, 32'h0001_0000);
		wb(1'b0, ADR_STATUS, 32'h0000_0000);
		chk("stopped flag", 1, rd[1]);
		chk("aborted flag", 0, rd[2]);
		rchk("gap ended", ADR_CTRL, 32'h0000_0001);
		wb(1'b1, ADR_STAT_CLR, 32'h0000_0007);
		wb(1'b1, ADR_CTRL, 32'h0000_0003);
		wb(1'b0, ADR_GAP_COUNT, 32'h0000_0000);
		chk("gap restart", 1, rd < 32'h0000_0040);
		close_out();
	end
endmodule
